// >>> core/ppx_consts.svh
// Constants for the program page expansion block
`ifndef PPX_CONSTS_SVH
`define PPX_CONSTS_SVH
`define PPX_PAGE_W 6
`define PPX_ADDR_W 16
`define PPX_PAGE_RESET 6'h00
`define PPX_WIN_LO 16'h8000
`define PPX_WIN_HI 16'hbfff
`define PPX_XA_REGION0 6'h3d
`define PPX_XA_REGION1 6'h3e
`define PPX_XA_REGION3 6'h3f
`define PPX_SPLIT_SW0 6'h38
`define PPX_SPLIT_SW1 6'h30
`define PPX_SPLIT_SW2 6'h20
`define PPX_SPLIT_SW3 6'h00
`define PPX_TEMP_RESET 6'h00
`define PPX_ADDR_RESET 16'h0000
`endif

// >>> core/ppx_pkg.sv
// Types for the program page expansion block
package ppx_pkg;
    typedef enum logic [2:0] {
        ppx_alloc_0k = 3'h0,
        ppx_alloc_16k = 3'h1,
        ppx_alloc_48k = 3'h2,
        ppx_alloc_64k = 3'h3
    } ppx_alloc_type;
    typedef enum logic [8:0] {
        ppx_idle = 9'h001,
        ppx_call_page = 9'h002,
        ppx_call_push_lo = 9'h004,
        ppx_call_push_hi = 9'h008,
        ppx_call_push_pg = 9'h010,
        ppx_call_jump = 9'h020,
        ppx_rtc_pull_pg = 9'h040,
        ppx_rtc_pull_ret = 9'h080,
        ppx_rtc_write = 9'h100
    } ppx_state_type;
endpackage

// >>> core/ppx_select_decode.sv
// Extended address and emulation select decoder
`timescale 1ns/1ps
`default_nettype none
`include "ppx_consts.svh"
module ppx_select_decode
    import ppx_pkg::*;
(
    input wire logic [15:0] core_address,
    input wire logic [5:0] page_index_bits,
    input wire logic page_internal,
    input wire ppx_alloc_type alloc,
    input wire logic rom_high_map_bit,
    output logic [5:0] next_extended_address_hi,
    output logic next_emulation_select_n
);
    wire logic [1:0] region;
    wire logic low_sel;
    assign region = core_address[15:14];
    assign next_extended_address_hi = (region == 2'h0) ? `PPX_XA_REGION0 :
                                      (region == 2'h1) ? `PPX_XA_REGION1 :
                                      (region == 2'h2) ? page_index_bits : `PPX_XA_REGION3;
    // Select-low flag; a 1 drives the active-low select low for this access
    assign low_sel = (region == 2'h3) ? 1'b1 :
                     (alloc == ppx_alloc_0k) ? (region == 2'h2) :
                     (alloc == ppx_alloc_16k) ? 1'b0 :
                     (region == 2'h2) ? page_internal :
                     (region == 2'h1) ? !rom_high_map_bit :
                     (alloc == ppx_alloc_64k) ? !rom_high_map_bit : 1'b0;
    assign next_emulation_select_n = !low_sel;
endmodule // ppx_select_decode
`default_nettype wire

// >>> core/ppx_top.sv
// Program page register, far call/return sequencer and expansion pin drive
//
// Contract
// - Six-bit page maps 16K into 0x8000-0xBFFF
// - Partition switches split window internal/external
// - Page register loads, stores, far call/return
// - Call: save, load page, push return, push page
// - Far call sequence is not interruptible
// - Call page immediate, or fetched when indirect
// - Return: pull page, pull return, write page
// - Far return uninterruptible, works from anywhere
// - Window access drives page onto extended lines
// - Outside window, extended lines carry fixed codes
// - 0K: select low for window and top
// - 16K: select low only for top block
// - 48K: mid block by high-map, window internal
// - 64K: low blocks by high-map bit too
// - Pins driven only with enable and expanded
// - Enable clear: select pin is general I/O
// - Normal write lands next cycle; far writes in-instruction
`timescale 1ns/1ps
`default_nettype none
`include "ppx_consts.svh"
module ppx_top
    import ppx_pkg::*;
#(
    parameter int PAGE_W = `PPX_PAGE_W
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] core_address,
    input wire logic [1:0] partition_switches,
    input wire ppx_alloc_type alloc,
    input wire logic rom_high_map_bit,
    input wire logic port_k_emulation_enable,
    input wire logic expanded_mode,
    input wire logic page_wr,
    input wire logic [5:0] page_wdata,
    output logic [5:0] page_rdata,
    input wire logic call_start,
    input wire logic call_indirect,
    input wire logic [5:0] call_imm_page,
    input wire logic [15:0] call_imm_target,
    input wire logic [15:0] call_return_addr,
    input wire logic [5:0] ind_page,
    input wire logic [15:0] ind_target,
    input wire logic rtc_start,
    input wire logic [5:0] stack_pull_page,
    input wire logic [15:0] stack_pull_addr,
    output logic push_valid,
    output logic [7:0] push_data,
    output logic pull_req,
    output logic seq_busy,
    output logic irq_inhibit,
    output logic jump_valid,
    output logic [15:0] jump_addr,
    output logic [5:0] extended_address_hi,
    output logic extended_address_oe,
    output logic emulation_select_n,
    output logic emulation_select_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe
);
    logic [5:0] program_page_register;
    logic [5:0] temp_page;
    logic [15:0] ret_addr;
    logic [15:0] target;
    logic [5:0] pulled_page;
    logic [5:0] call_page;
    ppx_state_type state;
    ppx_state_type next_state;
    logic [5:0] next_page;
    logic [7:0] next_push_data;
    logic next_push_valid;
    logic next_jump_valid;
    logic [15:0] next_jump_addr;
    wire logic page_internal;
    wire logic [5:0] dec_xa;
    wire logic dec_sel_n;
    wire logic pins_on;
    wire logic [5:0] new_page;
    wire logic [15:0] new_target;

    ppx_window_decode u_window
    (
        .partition_switches(partition_switches),
        .page_index_bits(program_page_register),
        .page_internal(page_internal)
    );

    ppx_select_decode u_select
    (
        .core_address(core_address),
        .page_index_bits(program_page_register),
        .page_internal(page_internal),
        .alloc(alloc),
        .rom_high_map_bit(rom_high_map_bit),
        .next_extended_address_hi(dec_xa),
        .next_emulation_select_n(dec_sel_n)
    );

    assign new_page = call_indirect ? ind_page : call_imm_page;
    assign new_target = call_indirect ? ind_target : call_imm_target;
    assign pins_on = port_k_emulation_enable && expanded_mode;

    // Pin decode is combinational so each access sees its own page
    assign extended_address_hi = pins_on ? dec_xa : 6'h00;
    assign extended_address_oe = pins_on;
    assign emulation_select_n = pins_on ? dec_sel_n : gpio_out;
    assign emulation_select_oe = pins_on ? 1'b1 : gpio_oe;

    assign page_rdata = program_page_register;
    assign seq_busy = (state != ppx_idle);
    // Interrupts held off across the whole sequence
    assign irq_inhibit = seq_busy || call_start || rtc_start;
    assign pull_req = (state == ppx_rtc_pull_pg) || (state == ppx_rtc_pull_ret);

    always_comb
    begin
        next_state = state;
        next_page = program_page_register;
        next_push_valid = 1'b0;
        next_push_data = 8'h00;
        next_jump_valid = 1'b0;
        next_jump_addr = jump_addr;
        case (state)
            ppx_idle:
            begin
                if (call_start)
                begin
                    next_state = ppx_call_page;
                end
                else if (rtc_start)
                begin
                    next_state = ppx_rtc_pull_pg;
                end
                else if (page_wr)
                begin
                    next_page = page_wdata;
                end
            end
            ppx_call_page:
            begin
                next_page = call_page;
                next_state = ppx_call_push_lo;
            end
            ppx_call_push_lo:
            begin
                next_push_valid = 1'b1;
                next_push_data = ret_addr[7:0];
                next_state = ppx_call_push_hi;
            end
            ppx_call_push_hi:
            begin
                next_push_valid = 1'b1;
                next_push_data = ret_addr[15:8];
                next_state = ppx_call_push_pg;
            end
            ppx_call_push_pg:
            begin
                next_push_valid = 1'b1;
                next_push_data = {2'h0, temp_page};
                next_state = ppx_call_jump;
            end
            ppx_call_jump:
            begin
                next_jump_valid = 1'b1;
                next_jump_addr = target;
                next_state = ppx_idle;
            end
            ppx_rtc_pull_pg:
            begin
                next_state = ppx_rtc_pull_ret;
            end
            ppx_rtc_pull_ret:
            begin
                next_state = ppx_rtc_write;
            end
            ppx_rtc_write:
            begin
                next_page = pulled_page;
                next_jump_valid = 1'b1;
                next_jump_addr = ret_addr;
                next_state = ppx_idle;
            end
            default:
            begin
                next_state = ppx_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ppx_idle;
            program_page_register <= `PPX_PAGE_RESET;
            push_valid <= 1'b0;
            push_data <= 8'h00;
            jump_valid <= 1'b0;
            jump_addr <= `PPX_ADDR_RESET;
        end
        else
        begin
            state <= next_state;
            program_page_register <= next_page;
            push_valid <= next_push_valid;
            push_data <= next_push_data;
            jump_valid <= next_jump_valid;
            jump_addr <= next_jump_addr;
        end
    end

    // Operands captured at start so the caller may change them afterwards
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            temp_page <= `PPX_TEMP_RESET;
            ret_addr <= `PPX_ADDR_RESET;
            target <= `PPX_ADDR_RESET;
            pulled_page <= `PPX_TEMP_RESET;
            call_page <= `PPX_TEMP_RESET;
        end
        else if (state == ppx_idle && call_start)
        begin
            temp_page <= program_page_register;
            call_page <= new_page;
            ret_addr <= call_return_addr;
            target <= new_target;
        end
        else if (state == ppx_rtc_pull_pg)
        begin
            pulled_page <= stack_pull_page;
        end
        else if (state == ppx_rtc_pull_ret)
        begin
            ret_addr <= stack_pull_addr;
        end
    end
endmodule // ppx_top
`default_nettype wire

// >>> core/ppx_window_decode.sv
// Window internal/external decoder from the partition switches
`timescale 1ns/1ps
`default_nettype none
`include "ppx_consts.svh"
module ppx_window_decode
    import ppx_pkg::*;
(
    input wire logic [1:0] partition_switches,
    input wire logic [5:0] page_index_bits,
    output logic page_internal
);
    wire logic [5:0] split;
    assign split = (partition_switches == 2'h0) ? `PPX_SPLIT_SW0 :
                   (partition_switches == 2'h1) ? `PPX_SPLIT_SW1 :
                   (partition_switches == 2'h2) ? `PPX_SPLIT_SW2 : `PPX_SPLIT_SW3;
    assign page_internal = (page_index_bits >= split);
endmodule // ppx_window_decode
`default_nettype wire

// >>> verif/ppx_stack_model.sv
// Stack memory standing behind the push and pull ports
`timescale 1ns/1ps
`default_nettype none
module ppx_stack_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic pull_req,
    output logic [5:0] stack_pull_page,
    output logic [15:0] stack_pull_addr
);
    logic [7:0] mem [0:15];
    logic [3:0] sp;
    logic pull_q;
    logic [7:0] churn;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sp <= 4'h0;
            pull_q <= 1'b0;
            churn <= 8'h00;
        end
        else
        begin
            pull_q <= pull_req;
            churn <= churn + 8'h5b;
            if (push_valid)
            begin
                mem[sp] <= push_data;
                sp <= sp + 4'h1;
            end
            else if (pull_q && !pull_req)
                sp <= sp - 4'h3;
        end
    end
    // Outside a pull the lines churn so a stale value can never look right
    assign stack_pull_page = pull_req ? mem[sp - 4'h1][5:0] : churn[5:0];
    assign stack_pull_addr = pull_req ? {mem[sp - 4'h2], mem[sp - 4'h3]} : {churn, ~churn};
endmodule // ppx_stack_model
`default_nettype wire

// >>> verif/ppx_top_monitor.sv
// Concurrent checks on the ports of the program page expansion block
`timescale 1ns/1ps
`default_nettype none
module ppx_top_monitor
    import ppx_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] core_address,
    input wire logic [1:0] partition_switches,
    input wire ppx_alloc_type alloc,
    input wire logic rom_high_map_bit,
    input wire logic port_k_emulation_enable,
    input wire logic expanded_mode,
    input wire logic page_wr,
    input wire logic [5:0] page_wdata,
    input wire logic [5:0] page_rdata,
    input wire logic call_start,
    input wire logic [15:0] call_return_addr,
    input wire logic rtc_start,
    input wire logic push_valid,
    input wire logic [7:0] push_data,
    input wire logic pull_req,
    input wire logic seq_busy,
    input wire logic irq_inhibit,
    input wire logic jump_valid,
    input wire logic [5:0] extended_address_hi,
    input wire logic extended_address_oe,
    input wire logic emulation_select_n,
    input wire logic emulation_select_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [1:0] region = core_address[15:14];
    wire pins_on = port_k_emulation_enable && expanded_mode;
    wire [5:0] split = partition_switches == 2'h0 ? 6'h38 : partition_switches == 2'h1 ? 6'h30 :
        partition_switches == 2'h2 ? 6'h20 : 6'h00;
    wire internal = page_rdata >= split;
    wire hi_rom = (alloc == ppx_alloc_48k || alloc == ppx_alloc_64k) && !rom_high_map_bit;
    wire exp_sel_n = region == 2'h0 ? !(alloc == ppx_alloc_64k && !rom_high_map_bit) : region == 2'h1 ? !hi_rom :
        region == 2'h2 ? (alloc == ppx_alloc_0k ? 1'b0 : alloc == ppx_alloc_16k ? 1'b1 : !internal) : 1'b0;
    wire [5:0] code = region == 2'h0 ? 6'h3d : region == 2'h1 ? 6'h3e : 6'h3f;
    wire call_go = call_start && !seq_busy;
    sequence s_pushes;
        ##3 (push_valid && push_data == $past(call_return_addr[7:0], 3))
        ##1 (push_valid && push_data == $past(call_return_addr[15:8], 4))
        ##1 (push_valid && push_data == {2'b00, $past(page_rdata, 5)});
    endsequence
    sequence s_call_body;
        ##1 (seq_busy && irq_inhibit)[*5] ##1 (jump_valid && !seq_busy);
    endsequence
    a_window_page: assert property (pins_on && region == 2'h2 |-> extended_address_hi == page_rdata)
        else $error("window page not on extended lines");
    a_fixed_codes: assert property (pins_on && region != 2'h2 |-> extended_address_hi == code)
        else $error("fixed region code wrong");
    a_select_map: assert property (pins_on |-> emulation_select_n == exp_sel_n && emulation_select_oe)
        else $error("emulation select wrong for region");
    a_pins_off: assert property (!pins_on |-> !extended_address_oe && extended_address_hi == 6'h00)
        else $error("extended lines driven while off");
    a_gpio_pass: assert property (!port_k_emulation_enable |-> emulation_select_n == gpio_out &&
        emulation_select_oe == gpio_oe)
        else $error("select pin not general I/O");
    a_call_seq: assert property (call_go |-> s_call_body)
        else $error("call sequence timing wrong");
    a_push_order: assert property (call_go |-> s_pushes)
        else $error("call push bytes wrong");
    a_rtc_seq: assert property (rtc_start && !call_start && !seq_busy |=>
        pull_req[*2] ##1 (seq_busy && !pull_req) ##1 (jump_valid && !seq_busy))
        else $error("return sequence timing wrong");
    a_page_write: assert property (page_wr && !seq_busy && !call_start && !rtc_start |=>
        page_rdata == $past(page_wdata))
        else $error("page write not seen next cycle");
endmodule // ppx_top_monitor
bind ppx_top ppx_top_monitor i_ppx_top_monitor (.*);
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking testbench for the program page expansion block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppx_pkg::*;
    logic clk = 0, resetn = 0, rom_high_map_bit = 0, port_k_emulation_enable = 0, expanded_mode = 0;
    logic page_wr = 0, call_start = 0, call_indirect = 0, rtc_start = 0, gpio_out = 0, gpio_oe = 0;
    logic [15:0] core_address = 0, call_imm_target = 0, call_return_addr = 0, ind_target = 0;
    logic [15:0] stack_pull_addr, jump_addr;
    logic [1:0] partition_switches = 0;
    ppx_alloc_type alloc = ppx_alloc_0k;
    logic [5:0] page_wdata = 0, call_imm_page = 0, ind_page = 0, page_rdata, stack_pull_page, extended_address_hi;
    logic push_valid, pull_req, seq_busy, irq_inhibit, jump_valid, extended_address_oe, emulation_select_n;
    logic emulation_select_oe;
    logic [7:0] push_data;
    logic [5:0] splits [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
    int bad_count = 0, checks = 0;
    ppx_top i_ppx_top (.*);
    ppx_stack_model i_ppx_stack_model (.*);
    always #5 clk = ~clk;
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] want);
        checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr_page(logic [5:0] p);
        page_wr = 1;
        page_wdata = p;
        step();
        page_wr = 0;
        step();
        check(page_rdata, p);
    endtask
    task automatic wait_jump;
        for (int n = 0; n < 12 && jump_valid !== 1'b1; n++)
            step();
        check(jump_valid, 1'b1);
    endtask
    task automatic t_regions;
        logic sel;
        port_k_emulation_enable = 1;
        expanded_mode = 1;
        wr_page(6'h2a);
        for (int a = 0; a < 4; a++)
            for (int h = 0; h < 2; h++)
                for (int r = 0; r < 4; r++)
                begin
                    alloc = ppx_alloc_type'(a);
                    rom_high_map_bit = h[0];
                    core_address = {r[1:0], 14'h0abc};
                    step();
                    check(extended_address_hi, r == 0 ? 6'h3d : r == 1 ? 6'h3e : r == 2 ? 6'h2a : 6'h3f);
                    // Page 0x2a is external with the switches at 00
                    sel = r == 3 ? 1'b0 : r == 2 ? a != 0 : r == 1 ? !(a > 1 && h == 0) : !(a == 3 && h == 0);
                    check(emulation_select_n, sel);
                end
    endtask
    task automatic t_window;
        alloc = ppx_alloc_48k;
        core_address = 16'h9000;
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 2; k++)
            begin
                partition_switches = s[1:0];
                wr_page(splits[s] - 6'(1 - k));
                check(emulation_select_n, s != 3 && k == 0);
            end
    endtask
    task automatic t_off;
        port_k_emulation_enable = 0;
        gpio_out = 1;
        gpio_oe = 1;
        step();
        check({emulation_select_n, emulation_select_oe, extended_address_oe}, 3'b110);
        gpio_out = 0;
        port_k_emulation_enable = 1;
        expanded_mode = 0;
        step();
        check({extended_address_oe, extended_address_hi}, 7'h00);
        expanded_mode = 1;
    endtask
    task automatic t_call(logic ind, logic [5:0] pg, logic [15:0] tgt, logic [15:0] ret);
        call_indirect = ind;
        call_imm_page = ind ? ~pg : pg;
        ind_page = ind ? pg : ~pg;
        call_imm_target = ind ? ~tgt : tgt;
        ind_target = ind ? tgt : ~tgt;
        call_return_addr = ret;
        call_start = 1;
        step();
        call_start = 0;
        // Operands may move once the call is taken
        call_indirect = !ind;
        page_wr = 1;
        page_wdata = 6'h15;
        check(irq_inhibit, 1'b1);
        wait_jump();
        page_wr = 0;
        check(jump_addr, tgt);
        check(page_rdata, pg);
    endtask
    task automatic t_rtc(logic [5:0] pg, logic [15:0] ret);
        rtc_start = 1;
        step();
        rtc_start = 0;
        check(pull_req, 1'b1);
        wait_jump();
        check(jump_addr, ret);
        check(page_rdata, pg);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        #1 resetn = 1;
        t_regions();
        t_window();
        t_off();
        wr_page(6'h05);
        core_address = 16'ha000;
        t_call(0, 6'h21, 16'hc100, 16'h8123);
        t_call(1, 6'h3a, 16'h9abc, 16'ha456);
        t_rtc(6'h21, 16'ha456);
        t_rtc(6'h05, 16'h8123);
        resetn = 0;
        step();
        check(page_rdata, 6'h00);
        check({push_valid, jump_valid, seq_busy}, 3'b000);
        resetn = 1;
        wr_page(6'h11);
        test_done();
    end
    // The scenarios need well under a thousand cycles; this margin only catches a hang
    initial
    begin
        #50000;
        bad_count++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
